// ### verilog/tpg_pkg.sv
// Constants for the three-port GPIO bank: register indices, resets, widths.
// Assumes AXI4-Lite with byte address = 4 * register index.
package tpg_pkg;
  localparam int unsigned NUM_PORTS = 3;
  localparam int unsigned PORT_W = 8;
  localparam int unsigned ADDR_W = 18;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_CFG_A = 16'h7f93;
  localparam logic [15:0] IDX_CFG_B = 16'h7f94;
  localparam logic [15:0] IDX_CFG_C = 16'h7f95;
  localparam logic [15:0] IDX_OUT_A = 16'h7f96;
  localparam logic [15:0] IDX_OUT_B = 16'h7f97;
  localparam logic [15:0] IDX_OUT_C = 16'h7f98;
  localparam logic [15:0] IDX_PIN_A = 16'h7f99;
  localparam logic [15:0] IDX_PIN_B = 16'h7f9a;
  localparam logic [15:0] IDX_PIN_C = 16'h7f9b;
  localparam logic [15:0] IDX_OE_A = 16'h7f9c;
  localparam logic [15:0] IDX_OE_B = 16'h7f9d;
  localparam logic [15:0] IDX_OE_C = 16'h7f9e;
  localparam logic [7:0] RST_OUT = 8'h00;
  localparam logic [7:0] RST_CFG = 8'h00;
  // Drive enables are undefined in the part; zero chosen so pins start as inputs
  localparam logic [7:0] RST_OE = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    TPG_KIND_CFG,
    TPG_KIND_OUT,
    TPG_KIND_PIN,
    TPG_KIND_OE
  } tpg_kind_t;
endpackage

// ### verilog/tpg_pin_if.sv
// Carrier between the bank and its pad block: per-port control and sampled level.
// Assumes one clock; the pad block owns the synchroniser.
`timescale 1ns/1ns
interface tpg_pin_if;
  logic [7:0] out_latch [3];
  logic [7:0] drive_en [3];
  logic [7:0] alt_sel [3];
  logic [7:0] level [3];
  modport bank (output out_latch, output drive_en, output alt_sel, input level);
  modport pad (input out_latch, input drive_en, input alt_sel, output level);
endinterface

// ### verilog/tpg_pad.sv
// Pad steering for 24 pins and the two-flop input synchroniser.
// Assumes alternate-function signals come from peripherals in the same clock.
`timescale 1ns/1ns
module tpg_pad (
  input wire logic clk_i,
  input wire logic resetn_i,
  tpg_pin_if.pad pins,
  input wire logic [23:0] pad_in_i,
  input wire logic [23:0] alt_out_i,
  input wire logic [23:0] alt_drive_i,
  output logic [23:0] pad_out_o,
  output logic [23:0] pad_oe_n_o,
  output logic [23:0] alt_in_o
);
  logic [23:0] sync1_q;
  logic [23:0] sync2_q;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_q <= 24'h000000;
      sync2_q <= 24'h000000;
    end else begin
      sync1_q <= pad_in_i;
      sync2_q <= sync1_q;
    end
  end

  for (genvar p = 0; p < 3; p++) begin : g_port
    assign pins.level[p] = sync2_q[p*8 +: 8];
    for (genvar b = 0; b < 8; b++) begin : g_pin
      localparam int unsigned K = p * 8 + b;
      logic sel_alt;
      assign sel_alt = pins.alt_sel[p][b];
      // latch drives only when enabled and not alternate
      assign pad_out_o[K] = sel_alt ? alt_out_i[K] : pins.out_latch[p][b];
      assign pad_oe_n_o[K] = sel_alt ? ~alt_drive_i[K] : ~pins.drive_en[p][b];
      assign alt_in_o[K] = sync2_q[K];
    end
  end
endmodule // tpg_pad

// ### verilog/tpg_bank.sv
// Three-port GPIO bank: AXI4-Lite register slave and pad steering.
// Assumes a single 25 MHz clock and asynchronous pad inputs.
`timescale 1ns/1ns
module tpg_bank (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [17:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [17:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [23:0] pad_in_i,
  input wire logic [23:0] alt_out_i,
  input wire logic [23:0] alt_drive_i,
  output logic [23:0] pad_out_o,
  output logic [23:0] pad_oe_n_o,
  output logic [23:0] alt_in_o
);
  tpg_pin_if pins ();

  logic [7:0] out_q [3];
  logic [7:0] oe_q [3];
  logic [7:0] cfg_q [3];
  logic aw_held_q;
  logic w_held_q;
  logic [17:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic do_write;

  // Decode a byte address to kind and port; valid only for word-aligned mapped registers
  function automatic logic decode(input logic [17:0] addr, output tpg_pkg::tpg_kind_t kind,
                                  output logic [1:0] port);
    logic [15:0] idx;
    logic hit;
    idx = addr[17:2];
    hit = (addr[1:0] == 2'b00);
    kind = tpg_pkg::TPG_KIND_CFG;
    port = 2'd0;
    if (idx >= tpg_pkg::IDX_CFG_A && idx <= tpg_pkg::IDX_CFG_C) begin
      kind = tpg_pkg::TPG_KIND_CFG;
      port = 2'(idx - tpg_pkg::IDX_CFG_A);
    end else if (idx >= tpg_pkg::IDX_OUT_A && idx <= tpg_pkg::IDX_OUT_C) begin
      kind = tpg_pkg::TPG_KIND_OUT;
      port = 2'(idx - tpg_pkg::IDX_OUT_A);
    end else if (idx >= tpg_pkg::IDX_PIN_A && idx <= tpg_pkg::IDX_PIN_C) begin
      kind = tpg_pkg::TPG_KIND_PIN;
      port = 2'(idx - tpg_pkg::IDX_PIN_A);
    end else if (idx >= tpg_pkg::IDX_OE_A && idx <= tpg_pkg::IDX_OE_C) begin
      kind = tpg_pkg::TPG_KIND_OE;
      port = 2'(idx - tpg_pkg::IDX_OE_A);
    end else begin
      hit = 1'b0;
    end
    return hit;
  endfunction

  // Address and data are accepted independently and held until the write is done; no new ones are accepted until the response leaves
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign do_write = aw_held_q && w_held_q && !bvalid_q;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 18'h00000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      w_held_q <= 1'b0;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata[7:0];
      wstrb0_q <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  // Register writes; only byte lane 0 carries data, upper lanes are ignored
  always_ff @(posedge clk_i or negedge resetn_i) begin
    tpg_pkg::tpg_kind_t kind;
    logic [1:0] port;
    logic hit;
    if (!resetn_i) begin
      for (int i = 0; i < 3; i++) begin
        out_q[i] <= tpg_pkg::RST_OUT;
        oe_q[i] <= tpg_pkg::RST_OE;
        cfg_q[i] <= tpg_pkg::RST_CFG;
      end
    end else if (do_write && wstrb0_q) begin
      hit = decode(awaddr_q, kind, port);
      if (hit) begin
        unique case (kind)
          tpg_pkg::TPG_KIND_OUT: out_q[port] <= wdata_q;
          tpg_pkg::TPG_KIND_OE: oe_q[port] <= wdata_q;
          tpg_pkg::TPG_KIND_CFG: cfg_q[port] <= wdata_q;
          tpg_pkg::TPG_KIND_PIN: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    tpg_pkg::tpg_kind_t kind;
    logic [1:0] port;
    if (!resetn_i) begin
      bvalid_q <= 1'b0;
      bresp_q <= tpg_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= decode(awaddr_q, kind, port) ? tpg_pkg::RESP_OKAY : tpg_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;

  // Read path; pin levels are the synchronised ones, two cycles behind the pad
  always_ff @(posedge clk_i or negedge resetn_i) begin
    tpg_pkg::tpg_kind_t kind;
    logic [1:0] port;
    logic hit;
    if (!resetn_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= tpg_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      hit = decode(s_axi_araddr, kind, port);
      rvalid_q <= 1'b1;
      rdata_q <= 32'h00000000;
      rresp_q <= hit ? tpg_pkg::RESP_OKAY : tpg_pkg::RESP_SLVERR;
      if (hit) begin
        unique case (kind)
          tpg_pkg::TPG_KIND_OUT: rdata_q[7:0] <= out_q[port];
          tpg_pkg::TPG_KIND_OE: rdata_q[7:0] <= oe_q[port];
          tpg_pkg::TPG_KIND_CFG: rdata_q[7:0] <= cfg_q[port];
          tpg_pkg::TPG_KIND_PIN: rdata_q[7:0] <= pins.level[port];
        endcase
      end
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  for (genvar p = 0; p < 3; p++) begin : g_ctl
    assign pins.out_latch[p] = out_q[p];
    assign pins.drive_en[p] = oe_q[p];
    assign pins.alt_sel[p] = cfg_q[p];
  end

  tpg_pad u_pad (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .pins(pins.pad),
    .pad_in_i(pad_in_i),
    .alt_out_i(alt_out_i),
    .alt_drive_i(alt_drive_i),
    .pad_out_o(pad_out_o),
    .pad_oe_n_o(pad_oe_n_o),
    .alt_in_o(alt_in_o)
  );
endmodule // tpg_bank

// ### testbench/tpg_bank_monitor.sv
// Checker for the bank's bus handshakes and pad sampling path.
// Assumes it is bound to tpg_bank and sees only its ports.
`timescale 1ns/1ns
module tpg_bank_monitor (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [23:0] pad_in_i,
  input wire logic [23:0] alt_in_o,
  input wire logic [23:0] pad_oe_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence pair_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence resp_taken;
    s_axi_bvalid && s_axi_bready;
  endsequence
  resp_follow_a: assert property (pair_taken |-> ##2 s_axi_bvalid)
    else $error("no write response");
  resp_once_a: assert property (resp_taken |=> !s_axi_bvalid)
    else $error("write response repeated");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during response");
  rd_follow_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read data");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during data");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  sync_two_a: assert property ($past(resetn_i, 2) |-> alt_in_o == $past(pad_in_i, 2))
    else $error("pad level not two cycles late");
  rst_idle_a: assert property ($rose(resetn_i) |-> pad_oe_n_o == 24'hffffff)
    else $error("pin driven after reset");
endmodule // tpg_bank_monitor
bind tpg_bank tpg_bank_monitor u_mon (.clk_i, .resetn_i, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rdata, .pad_in_i, .alt_in_o, .pad_oe_n_o);

// ### testbench/tpg_pin_dev.sv
// Pin-side model: external parts that hold undriven pins at a commanded level.
// Assumes active-low enables; a driven pin reads back what the bank drives.
`timescale 1ns/1ns
module tpg_pin_dev (
  input wire logic [23:0] pad_out_i,
  input wire logic [23:0] pad_oe_n_i,
  input wire logic [23:0] ext_i,
  output logic [23:0] pad_o
);
  assign pad_o = (~pad_oe_n_i & pad_out_i) | (pad_oe_n_i & ext_i);
endmodule // tpg_pin_dev

// ### testbench/tb_top.sv
// Self-checking bench for the GPIO bank over AXI4-Lite.
// Assumes the pin model and the bound checker are compiled beforehand.
`timescale 1ns/1ns
module tb_top;
  typedef struct {logic [15:0] i; logic [7:0] d; logic [7:0] e;} tpg_row_t;
  logic clk_i, resetn_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [23:0] pad_in_i, alt_out_i, alt_drive_i, pad_out_o, pad_oe_n_o, alt_in_o, ext;
  logic [7:0] v;
  int fail_count, n_compared;
  // Pin C row reads back only the pins that port C drives
  tpg_row_t rows[5] = '{'{16'h7f93, 8'h3c, 8'h3c}, '{16'h7f96, 8'h81, 8'h81}, '{16'h7f98, 8'h7e, 8'h7e},
    '{16'h7f9e, 8'h42, 8'h42}, '{16'h7f9b, 8'hff, 8'h42}};
  tpg_bank uut (.clk_i, .resetn_i, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pad_in_i, .alt_out_i, .alt_drive_i, .pad_out_o,
    .pad_oe_n_o, .alt_in_o);
  tpg_pin_dev dev (.pad_out_i(pad_out_o), .pad_oe_n_i(pad_oe_n_o), .ext_i(ext), .pad_o(pad_in_i));
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // Ready is sampled at the falling edge, where it has settled for the next rise
  task automatic wr(input logic [15:0] i, input logic [7:0] d, input logic [1:0] er);
    bit ha, hw, hb;
    logic [1:0] r;
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(negedge clk_i);
      ha = s_axi_awvalid & s_axi_awready;
      hw = s_axi_wvalid & s_axi_wready;
      hb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk_i);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end while (!hb);
    chk("bresp", {22'h0, er}, {22'h0, r});
  endtask
  task automatic rd(input logic [15:0] i, input logic [1:0] er, output logic [7:0] d);
    bit h, hr;
    logic [31:0] q;
    logic [1:0] r;
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge clk_i);
      h = s_axi_arvalid & s_axi_arready;
      hr = s_axi_rvalid;
      q = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk_i);
      if (h) s_axi_arvalid <= 1'b0;
    end while (!hr);
    chk("rresp", {22'h0, er}, {22'h0, r});
    d = q[7:0];
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // Whole run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    {resetn_i, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, fail_count, n_compared} = '0;
    {s_axi_bready, s_axi_rready} = 2'h3;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, alt_out_i, alt_drive_i, ext} = '0;
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    for (int k = 0; k < 12; k++) begin
      if (k < 6 || k > 8) begin
        rd(16'h7f93 + 16'(k), tpg_pkg::RESP_OKAY, v);
        chk("reset value", 24'h0, {16'h0, v});
      end
    end
    $display("reset values done");
    foreach (rows[k]) begin
      wr(rows[k].i, rows[k].d, tpg_pkg::RESP_OKAY);
      rd(rows[k].i, tpg_pkg::RESP_OKAY, v);
      chk("readback", {16'h0, rows[k].e}, {16'h0, v});
    end
    $display("row table done");
    wr(16'h7f9d, 8'h00, tpg_pkg::RESP_OKAY);
    wr(16'h7f97, 8'h5a, tpg_pkg::RESP_OKAY);
    @(negedge clk_i);
    chk("oe_n b", 24'hff, {16'h0, pad_oe_n_o[15:8]});
    // Requests start only just after a rising edge
    @(posedge clk_i);
    rd(16'h7f97, tpg_pkg::RESP_OKAY, v);
    chk("latch b", 24'h5a, {16'h0, v});
    wr(16'h7f9d, 8'hff, tpg_pkg::RESP_OKAY);
    @(negedge clk_i);
    chk("pad b", 24'h5a, {16'h0, pad_out_o[15:8]});
    chk("oe_n b", 24'h0, {16'h0, pad_oe_n_o[15:8]});
    @(posedge clk_i);
    $display("drive enable done");
    alt_out_i <= 24'h000500;
    alt_drive_i <= 24'h000c00;
    wr(16'h7f94, 8'h0f, tpg_pkg::RESP_OKAY);
    @(negedge clk_i);
    chk("alt pad b", 24'h55, {16'h0, pad_out_o[15:8]});
    chk("alt oe_n b", 24'h03, {16'h0, pad_oe_n_o[15:8]});
    @(posedge clk_i);
    rd(16'h7f9a, tpg_pkg::RESP_OKAY, v);
    chk("pin b", 24'h54, {16'h0, v});
    $display("alternate done");
    rd(16'h7f9f, tpg_pkg::RESP_SLVERR, v);
    chk("unmapped data", 24'h0, {16'h0, v});
    wr(16'h7f9f, 8'hff, tpg_pkg::RESP_SLVERR);
    $display("unmapped done");
    resetn_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("oe_n in reset", 24'hffffff, pad_oe_n_o);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    rd(16'h7f97, tpg_pkg::RESP_OKAY, v);
    chk("latch after reset", 24'h0, {16'h0, v});
    $display("second reset done");
    tally_and_finish();
  end
endmodule // tb_top
